// >>> hw/uaff_uart.sv
// serial transceiver with FIFOs, RTS/CTS flow control and Wishbone regs
`timescale 1ns/1ps
`default_nettype none
`include "uaff_defines.svh"
module uaff_uart import uaff_pkg::*; #(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_stb_i,
  input wire logic wb_cyc_i,
  output logic wb_ack_o,
  input wire logic rxdPin,
  output logic txdPin,
  input wire logic ctsPin,
  output logic rtsPin,
  output logic irq
);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  typedef struct packed {
    logic [31:0] lineCtrl;
    logic [31:0] thresh;
    logic [31:0] irqEn;
    logic [31:0] irqFl;
    logic [31:0] rateInt;
    logic [31:0] rateFrac;
    logic [31:0] dmaCfg;
    logic ackQ;
    logic [31:0] rdDataQ;
    logic rxdMeta;
    logic rxdSync;
    logic ctsMeta;
    logic ctsSync;
    logic ctsPrev;
    logic txd;
    logic rts;
    uaff_tx_state_t txSt;
    logic [7:0] txShift;
    logic txPar;
    logic [1:0] txHalf;
    logic [2:0] txBit;
    uaff_rx_state_t rxSt;
    logic [7:0] rxShift;
    logic rxHalf;
    logic [2:0] rxBit;
    logic rxParQ;
    logic breakRun;
    logic [4:0] idleHalf;
    logic [7:0] idleFrames;
    logic idleEvt;
  } uaff_state_t;

  uaff_state_t q, d;

  logic [CW-1:0] txCount, rxCount;
  logic txFull, txEmpty, rxFull, rxEmpty;
  logic [7:0] txHead, rxHead;
  logic txPush, txPop, rxPush, rxPop;
  logic txFlush, rxFlush;
  logic txRestart, rxRestart;
  logic txHalfTick, rxHalfTick;
  logic [7:0] rxPushData;

  // ==========================================================
  // frame helpers
  function automatic logic [7:0] dataMask(input logic [3:0] nBits);
    dataMask = 8'hFF >> (4'd8 - nBits);
  endfunction : dataMask

  function automatic logic parityBit(input logic [7:0] data,
      input logic [3:0] nBits, input logic [1:0] mode, input logic lvl);
    logic ones;
    logic basePar;
    ones = ^(data & dataMask(nBits));
    // RULE14 zero or one count
    basePar = lvl ? ones : ones ^ nBits[0];
    // RULE15 parity mode encoding
    unique case (uaff_par_mode_t'(mode))
      PAR_EVEN: parityBit = basePar;
      PAR_ODD: parityBit = ~basePar;
      PAR_MARK: parityBit = 1'b1;
      PAR_SPACE: parityBit = 1'b0;
    endcase
  endfunction : parityBit

  // ==========================================================
  // FIFOs and bit-rate generators
  // RULE23 32-byte FIFOs
  uaff_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) txFifo (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .flush(txFlush),
    .push(txPush),
    .pushData(wb_dat_i[7:0]),
    .pop(txPop),
    .popData(txHead),
    .count(txCount),
    .full(txFull),
    .empty(txEmpty)
  );

  uaff_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rxFifo (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .flush(rxFlush),
    .push(rxPush),
    .pushData(rxPushData),
    .pop(rxPop),
    .popData(rxHead),
    .count(rxCount),
    .full(rxFull),
    .empty(rxEmpty)
  );

  // RULE17 rate generator runs only while enabled
  uaff_baud txBaud (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .run(q.lineCtrl[`UAFF_B_ENABLE]),
    .restart(txRestart),
    .frameAcc(~q.lineCtrl[`UAFF_B_BITACC]),
    .clkdiv(q.rateInt[`UAFF_F_CLKDIV]),
    .ibaud(q.rateInt[`UAFF_F_IBAUD]),
    .dbaud(q.rateFrac[`UAFF_F_DBAUD]),
    .halfTick(txHalfTick)
  );

  // RULE13 accuracy select
  uaff_baud rxBaud (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .run(q.lineCtrl[`UAFF_B_ENABLE]),
    .restart(rxRestart),
    .frameAcc(~q.lineCtrl[`UAFF_B_BITACC]),
    .clkdiv(q.rateInt[`UAFF_F_CLKDIV]),
    .ibaud(q.rateInt[`UAFF_F_IBAUD]),
    .dbaud(q.rateFrac[`UAFF_F_DBAUD]),
    .halfTick(rxHalfTick)
  );

  assign wb_ack_o = q.ackQ;
  assign wb_dat_o = q.rdDataQ;
  assign txdPin = q.txd;
  assign rtsPin = q.rts;
  // RULE27 interrupt request
  assign irq = |(q.irqFl[9:0] & q.irqEn[9:0]);

  // ==========================================================
  // next-state logic
  logic en, brk, flow, pol, parEn, ctsOk, reqNew, txLine;
  logic [3:0] nBits;
  logic [1:0] stopHalves;
  logic [4:0] frameHalves;
  logic [9:0] evt;
  logic [31:0] byteMask, wdMask, status;
  logic [7:0] rxData;

  always_comb begin
    d = q;
    txPush = 1'b0;
    txPop = 1'b0;
    rxPush = 1'b0;
    rxPop = 1'b0;
    txRestart = 1'b0;
    rxRestart = 1'b0;
    evt = '0;
    en = q.lineCtrl[`UAFF_B_ENABLE];
    brk = q.lineCtrl[`UAFF_B_BREAK];
    flow = q.lineCtrl[`UAFF_B_FLOW];
    pol = q.lineCtrl[`UAFF_B_FLOWPOL];
    parEn = q.lineCtrl[`UAFF_B_PAR_EN];
    // RULE12 character size
    nBits = 4'd5 + {2'b00, q.lineCtrl[`UAFF_F_SIZE]};
    // RULE11 stop length in half bits, less one
    stopHalves = !q.lineCtrl[`UAFF_B_STOP] ? 2'd1
      : (nBits == 4'd5 ? 2'd2 : 2'd3);
    frameHalves = 5'd2 + {nBits, 1'b0} + {3'b000, parEn, 1'b0}
      + 5'(stopHalves) + 5'd1;
    rxData = (q.rxShift >> (4'd8 - nBits));
    rxPushData = rxData;

    // pins pass two flops before any logic reads them
    d.rxdMeta = rxdPin;
    d.rxdSync = q.rxdMeta;
    d.ctsMeta = ctsPin;
    d.ctsSync = q.ctsMeta;
    d.ctsPrev = q.ctsSync;

    // RULE1 receive flush
    // RULE3 disable flushes both
    rxFlush = q.lineCtrl[`UAFF_B_RXFLUSH] | ~en;
    // RULE2 transmit flush
    txFlush = q.lineCtrl[`UAFF_B_TXFLUSH] | ~en;
    d.lineCtrl[`UAFF_B_RXFLUSH] = 1'b0;
    d.lineCtrl[`UAFF_B_TXFLUSH] = 1'b0;

    // RULE4 hardware flow control
    // RULE5 asserted level from polarity bit
    ctsOk = ~flow | (q.ctsSync == pol);
    if (flow && (q.ctsSync != q.ctsPrev)) begin
      evt[IRQ_CTS] = 1'b1;
    end
    // RULE7 stop remote at threshold
    // RULE8 reassert below threshold
    d.rts = (flow && (6'(rxCount) < q.thresh[`UAFF_F_RTSLVL])) ? pol : ~pol;

    // ========================================================
    // transmitter
    unique case (q.txSt)
      TXS_IDLE: begin
        // RULE6 start only while CTS asserted
        if (en && !brk && !txEmpty && ctsOk) begin
          txPop = 1'b1;
          txRestart = 1'b1;
          d.txShift = txHead;
          d.txPar = parityBit(txHead, nBits,
            q.lineCtrl[`UAFF_F_PAR_MODE], q.lineCtrl[`UAFF_B_PAR_LVL]);
          d.txHalf = '0;
          d.txSt = TXS_START;
        end
      end
      TXS_START: begin
        if (txHalfTick) begin
          d.txHalf = q.txHalf + 2'd1;
          if (q.txHalf[0]) begin
            d.txHalf = '0;
            d.txBit = '0;
            d.txSt = TXS_DATA;
          end
        end
      end
      TXS_DATA: begin
        if (txHalfTick) begin
          d.txHalf = q.txHalf + 2'd1;
          if (q.txHalf[0]) begin
            d.txHalf = '0;
            d.txShift = q.txShift >> 1;
            d.txBit = q.txBit + 3'd1;
            if ({1'b0, q.txBit} == nBits - 4'd1) begin
              // RULE16 optional parity bit
              d.txSt = parEn ? TXS_PAR : TXS_STOP;
            end
          end
        end
      end
      TXS_PAR: begin
        if (txHalfTick) begin
          d.txHalf = q.txHalf + 2'd1;
          if (q.txHalf[0]) begin
            d.txHalf = '0;
            d.txSt = TXS_STOP;
          end
        end
      end
      TXS_STOP: begin
        // RULE11 stop length
        if (txHalfTick) begin
          d.txHalf = q.txHalf + 2'd1;
          if (q.txHalf == stopHalves) begin
            d.txSt = TXS_IDLE;
          end
        end
      end
    endcase
    if (!en) begin
      d.txSt = TXS_IDLE;
    end
    unique case (d.txSt)
      TXS_IDLE: txLine = 1'b1;
      TXS_START: txLine = 1'b0;
      TXS_DATA: txLine = d.txShift[0];
      TXS_PAR: txLine = d.txPar;
      TXS_STOP: txLine = 1'b1;
    endcase
    // RULE10 break holds the line low
    d.txd = (en && brk) ? 1'b0 : txLine;

    // ========================================================
    // receiver, sampling at mid bit
    if (rxHalfTick && q.rxSt != RXS_IDLE) begin
      d.rxHalf = ~q.rxHalf;
    end
    unique case (q.rxSt)
      RXS_IDLE: begin
        if (q.rxdSync && q.breakRun) begin
          // RULE26 line back high ends the break run
          evt[IRQ_LASTBREAK] = 1'b1;
          d.breakRun = 1'b0;
        end
        if (en && !q.rxdSync) begin
          rxRestart = 1'b1;
          d.rxHalf = 1'b0;
          d.rxShift = '0;
          d.rxParQ = 1'b0;
          d.rxSt = RXS_START;
        end
      end
      RXS_START: begin
        if (rxHalfTick && !q.rxHalf) begin
          d.rxBit = '0;
          d.rxSt = q.rxdSync ? RXS_IDLE : RXS_DATA;
        end
      end
      RXS_DATA: begin
        if (rxHalfTick && !q.rxHalf) begin
          d.rxShift = {q.rxdSync, q.rxShift[7:1]};
          d.rxBit = q.rxBit + 3'd1;
          if ({1'b0, q.rxBit} == nBits - 4'd1) begin
            d.rxSt = parEn ? RXS_PAR : RXS_STOP;
          end
        end
      end
      RXS_PAR: begin
        if (rxHalfTick && !q.rxHalf) begin
          d.rxParQ = q.rxdSync;
          d.rxSt = RXS_STOP;
        end
      end
      RXS_STOP: begin
        if (rxHalfTick && !q.rxHalf) begin
          d.rxSt = RXS_IDLE;
          if (!q.rxdSync && q.rxShift == '0 && !q.rxParQ) begin
            // RULE26 only the first break raises a flag
            if (!q.breakRun) begin
              evt[IRQ_BREAK] = 1'b1;
            end
            d.breakRun = 1'b1;
          end else begin
            rxPush = 1'b1;
            // RULE22 overrun on push into full FIFO
            evt[IRQ_OVERRUN] = rxFull;
            evt[IRQ_FRAME] = ~q.rxdSync;
            evt[IRQ_PARITY] = parEn && (q.rxParQ != parityBit(rxData,
              nBits, q.lineCtrl[`UAFF_F_PAR_MODE],
              q.lineCtrl[`UAFF_B_PAR_LVL]));
            if (q.breakRun) begin
              evt[IRQ_LASTBREAK] = 1'b1;
              d.breakRun = 1'b0;
            end
          end
        end
      end
    endcase
    if (!en) begin
      d.rxSt = RXS_IDLE;
    end

    // ========================================================
    // RULE9 idle frame limit while data waits
    if (rxEmpty || rxPush) begin
      d.idleHalf = '0;
      d.idleFrames = '0;
      d.idleEvt = 1'b0;
    end else if (rxHalfTick && !q.idleEvt &&
        q.lineCtrl[`UAFF_F_IDLE_LIMIT] != 8'h00) begin
      d.idleHalf = q.idleHalf + 5'd1;
      if (q.idleHalf == frameHalves - 5'd1) begin
        d.idleHalf = '0;
        d.idleFrames = q.idleFrames + 8'd1;
        if (q.idleFrames + 8'd1 == q.lineCtrl[`UAFF_F_IDLE_LIMIT]) begin
          d.idleEvt = 1'b1;
          evt[IRQ_IDLE] = 1'b1;
        end
      end
    end

    // RULE18 transmit level flag
    evt[IRQ_TXLVL] = 6'(txCount) >= q.thresh[`UAFF_F_TXLVL];
    // RULE19 receive level flag
    evt[IRQ_RXLVL] = 6'(rxCount) >= q.thresh[`UAFF_F_RXLVL];
    evt[IRQ_TXAE] = (txCount == CW'(1));

    // ========================================================
    // Wishbone slave, one wait state
    reqNew = wb_cyc_i & wb_stb_i & ~q.ackQ;
    d.ackQ = reqNew;
    byteMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
      {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wdMask = '0;
    // RULE20 occupancy counts
    // RULE21 live full and empty flags
    status = {7'h00, q.idleEvt, 2'b00, 6'(txCount), 2'b00, 6'(rxCount),
      txFull, txEmpty, rxFull, rxEmpty, q.breakRun, q.rxParQ,
      q.rxSt != RXS_IDLE, q.txSt != TXS_IDLE};
    // RULE24 set wins over write-one clear
    d.irqFl = q.irqFl;
    if (reqNew && wb_we_i) begin
      unique case ({wb_adr_i[7:2], 2'b00})
        `UAFF_OFS_LINE_CONTROL: wdMask = `UAFF_WM_LINE_CONTROL;
        `UAFF_OFS_FIFO_THRESHOLD: wdMask = `UAFF_WM_THRESHOLD;
        `UAFF_OFS_IRQ_ENABLE: wdMask = `UAFF_WM_IRQ;
        `UAFF_OFS_IRQ_FLAGS: begin
          d.irqFl = q.irqFl & ~(wb_dat_i & byteMask & `UAFF_WM_IRQ);
        end
        `UAFF_OFS_RATE_INTEGER: wdMask = `UAFF_WM_RATE_INTEGER;
        `UAFF_OFS_RATE_FRACTION: wdMask = `UAFF_WM_RATE_FRACTION;
        // RULE25 write pushes transmit FIFO
        `UAFF_OFS_DATA_PORT: txPush = wb_sel_i[0] & ~txFull;
        `UAFF_OFS_DMA_CONFIG: wdMask = `UAFF_WM_DMA;
        default: wdMask = '0;
      endcase
      wdMask = wdMask & byteMask;
      unique case ({wb_adr_i[7:2], 2'b00})
        `UAFF_OFS_LINE_CONTROL: d.lineCtrl = (d.lineCtrl & ~wdMask)
          | (wb_dat_i & wdMask);
        `UAFF_OFS_FIFO_THRESHOLD: d.thresh = (q.thresh & ~wdMask)
          | (wb_dat_i & wdMask);
        `UAFF_OFS_IRQ_ENABLE: d.irqEn = (q.irqEn & ~wdMask)
          | (wb_dat_i & wdMask);
        `UAFF_OFS_RATE_INTEGER: d.rateInt = (q.rateInt & ~wdMask)
          | (wb_dat_i & wdMask);
        `UAFF_OFS_RATE_FRACTION: d.rateFrac = (q.rateFrac & ~wdMask)
          | (wb_dat_i & wdMask);
        `UAFF_OFS_DMA_CONFIG: d.dmaCfg = (q.dmaCfg & ~wdMask)
          | (wb_dat_i & wdMask);
        default: ;
      endcase
    end
    d.irqFl[9:0] = d.irqFl[9:0] | evt;
    if (reqNew && !wb_we_i) begin
      unique case ({wb_adr_i[7:2], 2'b00})
        `UAFF_OFS_LINE_CONTROL: d.rdDataQ = q.lineCtrl;
        `UAFF_OFS_FIFO_THRESHOLD: d.rdDataQ = q.thresh;
        `UAFF_OFS_LINE_STATUS: d.rdDataQ = status;
        `UAFF_OFS_IRQ_ENABLE: d.rdDataQ = q.irqEn;
        `UAFF_OFS_IRQ_FLAGS: d.rdDataQ = q.irqFl;
        `UAFF_OFS_RATE_INTEGER: d.rdDataQ = q.rateInt;
        `UAFF_OFS_RATE_FRACTION: d.rdDataQ = q.rateFrac;
        `UAFF_OFS_DATA_PORT: begin
          // RULE25 read pops receive FIFO
          rxPop = ~rxEmpty;
          d.rdDataQ = {24'h00_0000, rxEmpty ? 8'h00 : rxHead};
        end
        `UAFF_OFS_DMA_CONFIG: d.rdDataQ = q.dmaCfg;
        `UAFF_OFS_TRANSMIT_PEEK: begin
          d.rdDataQ = {24'h00_0000, txEmpty ? 8'h00 : txHead};
        end
        default: d.rdDataQ = '0;
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
      q.lineCtrl <= `UAFF_REG_RESET;
      q.rxdMeta <= 1'b1;
      q.rxdSync <= 1'b1;
      q.txd <= 1'b1;
      q.rts <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

endmodule : uaff_uart
`default_nettype wire

// >>> hw/uaff_defines.svh
// register offsets, field positions and reset values of the serial port
// Operation
// RULE1 - receive flush bit empties receive FIFO, self-clears
// RULE2 - transmit flush bit empties transmit FIFO, self-clears
// RULE3 - clearing enable flushes both FIFOs
// RULE4 - flow enable bit hands RTS/CTS to hardware
// RULE5 - polarity bit picks asserted level of RTS/CTS
// RULE6 - start only with CTS asserted, finish current character
// RULE7 - deassert RTS when receive level reaches threshold
// RULE8 - reassert RTS when receive level drops below threshold
// RULE9 - receive idle event after programmed idle frame count
// RULE10 - break bit forces transmit line to zero
// RULE11 - stop bit selects one, 1.5 or two stops
// RULE12 - size field gives five to eight data bits
// RULE13 - accuracy bit: frame accuracy or fixed bit width
// RULE14 - parity level counts zero or one bits
// RULE15 - parity mode even, odd, mark, space
// RULE16 - parity enable appends parity bit after data
// RULE17 - enable bit starts rate generator and transceiver
// RULE18 - transmit level flag when count at least threshold
// RULE19 - receive level flag when count reaches threshold
// RULE20 - status shows transmit and receive FIFO counts
// RULE21 - live full and empty flags, empties reset high
// RULE22 - overrun event on push into full receive FIFO
// RULE23 - each FIFO holds 32 bytes
// RULE24 - flags clear only by writing one
// RULE25 - data port read pops, write pushes
// RULE26 - break run flags first and last break only
// RULE27 - interrupt request while enabled flag is set
`ifndef UAFF_DEFINES_SVH
`define UAFF_DEFINES_SVH

// ==========================================================
// register offsets
`define UAFF_OFS_LINE_CONTROL 8'h00
`define UAFF_OFS_FIFO_THRESHOLD 8'h04
`define UAFF_OFS_LINE_STATUS 8'h08
`define UAFF_OFS_IRQ_ENABLE 8'h0C
`define UAFF_OFS_IRQ_FLAGS 8'h10
`define UAFF_OFS_RATE_INTEGER 8'h14
`define UAFF_OFS_RATE_FRACTION 8'h18
`define UAFF_OFS_DATA_PORT 8'h1C
`define UAFF_OFS_DMA_CONFIG 8'h20
`define UAFF_OFS_TRANSMIT_PEEK 8'h24

// ==========================================================
// line control fields
`define UAFF_B_ENABLE 0
`define UAFF_B_PAR_EN 1
`define UAFF_F_PAR_MODE 3:2
`define UAFF_B_PAR_LVL 4
`define UAFF_B_TXFLUSH 5
`define UAFF_B_RXFLUSH 6
`define UAFF_B_BITACC 7
`define UAFF_F_SIZE 9:8
`define UAFF_B_STOP 10
`define UAFF_B_FLOW 11
`define UAFF_B_FLOWPOL 12
`define UAFF_B_BREAK 14
`define UAFF_F_IDLE_LIMIT 23:16

// ==========================================================
// threshold and rate fields
`define UAFF_F_RXLVL 5:0
`define UAFF_F_TXLVL 13:8
`define UAFF_F_RTSLVL 21:16
`define UAFF_F_CLKDIV 18:16
`define UAFF_F_IBAUD 11:0
`define UAFF_F_DBAUD 11:0

// ==========================================================
// writable bit masks and reset value
`define UAFF_WM_LINE_CONTROL 32'h00FF_FFFF
`define UAFF_WM_THRESHOLD 32'h003F_3F3F
`define UAFF_WM_IRQ 32'h0000_03FF
`define UAFF_WM_RATE_INTEGER 32'h0007_0FFF
`define UAFF_WM_RATE_FRACTION 32'h0000_0FFF
`define UAFF_WM_DMA 32'h003F_3F03
`define UAFF_REG_RESET 32'h0000_0000

`endif

// >>> hw/uaff_pkg.sv
// types shared by the serial port modules
package uaff_pkg;

  typedef enum logic [2:0] {
    TXS_IDLE, TXS_START, TXS_DATA, TXS_PAR, TXS_STOP
  } uaff_tx_state_t;

  typedef enum logic [2:0] {
    RXS_IDLE, RXS_START, RXS_DATA, RXS_PAR, RXS_STOP
  } uaff_rx_state_t;

  typedef enum logic [1:0] {
    PAR_EVEN, PAR_ODD, PAR_MARK, PAR_SPACE
  } uaff_par_mode_t;

  // flag positions in the interrupt enable and flag registers
  typedef enum logic [3:0] {
    IRQ_FRAME, IRQ_PARITY, IRQ_CTS, IRQ_OVERRUN, IRQ_RXLVL,
    IRQ_TXAE, IRQ_TXLVL, IRQ_BREAK, IRQ_IDLE, IRQ_LASTBREAK
  } uaff_irq_t;

endpackage : uaff_pkg

// >>> hw/uaff_fifo.sv
// byte FIFO with flush, occupancy count and full/empty flags
`timescale 1ns/1ps
`default_nettype none
module uaff_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic flush,
  input wire logic push,
  input wire logic [WIDTH-1:0] pushData,
  input wire logic pop,
  output logic [WIDTH-1:0] popData,
  output logic [$clog2(DEPTH+1)-1:0] count,
  output logic full,
  output logic empty
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [CW-1:0] cnt;
  } uaff_fifo_state_t;

  uaff_fifo_state_t q, d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic doPush;
  logic doPop;

  assign full = (q.cnt == CW'(DEPTH));
  assign empty = (q.cnt == '0);
  assign count = q.cnt;
  assign popData = mem[q.rdPtr];

  always_comb begin
    d = q;
    doPush = push & ~full & ~flush;
    doPop = pop & ~empty & ~flush;
    if (doPush) begin
      d.wrPtr = (q.wrPtr == PW'(DEPTH - 1)) ? '0 : q.wrPtr + 1'b1;
    end
    if (doPop) begin
      d.rdPtr = (q.rdPtr == PW'(DEPTH - 1)) ? '0 : q.rdPtr + 1'b1;
    end
    d.cnt = q.cnt + CW'(doPush) - CW'(doPop);
    // a flush wins over a push or pop in the same cycle
    if (flush) begin
      d = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && doPush) begin
      mem[q.wrPtr] <= pushData;
    end
  end

endmodule : uaff_fifo
`default_nettype wire

// >>> hw/uaff_baud.sv
// half-bit tick generator with integer and fractional divisor
`timescale 1ns/1ps
`default_nettype none
module uaff_baud (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic run,
  input wire logic restart,
  input wire logic frameAcc,
  input wire logic [2:0] clkdiv,
  input wire logic [11:0] ibaud,
  input wire logic [11:0] dbaud,
  output logic halfTick
);
  typedef struct packed {
    logic [20:0] cnt;
    logic phase;
    logic [6:0] acc;
    logic tick;
  } uaff_baud_state_t;

  uaff_baud_state_t q, d;
  logic [20:0] divider;
  logic [20:0] fracProd;
  logic [7:0] accSum;
  logic [20:0] period;
  logic [20:0] target;

  assign halfTick = q.tick;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    divider = 21'h0_0080 >> clkdiv;
    fracProd = 21'(dbaud) * divider;
    accSum = {1'b0, q.acc} + {1'b0, fracProd[6:0]};
    // frame accuracy lets the carry stretch single bits; bit accuracy
    // keeps every bit the same width and drops the carry
    period = 21'(ibaud) * divider + (fracProd >> 7)
      + 21'(frameAcc & accSum[7]);
    if (period < 21'h0_0002) begin
      period = 21'h0_0002;
    end
    target = q.phase ? period - (period >> 1) : period >> 1;
    if (!run || restart) begin
      d.cnt = '0;
      d.phase = 1'b0;
      if (!run) begin
        d.acc = '0;
      end
    end else if (q.cnt == target - 21'h0_0001) begin
      d.cnt = '0;
      d.tick = 1'b1;
      d.phase = ~q.phase;
      if (q.phase && frameAcc) begin
        d.acc = accSum[6:0];
      end
    end else begin
      d.cnt = q.cnt + 21'h0_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

endmodule : uaff_baud
`default_nettype wire

// >>> tb/uaff_chk.sv
// bus and line assertions for the serial port
`timescale 1ns/1ps
`default_nettype none
module uaff_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic wb_stb_i,
  input wire logic wb_cyc_i,
  input wire logic wb_ack_o,
  input wire logic txdPin,
  input wire logic rtsPin,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // =====
  // properties
  chk_ack_follows: assert property (
    ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_ack_idle: assert property (
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack while bus idle");
  chk_read_hold: assert property (wb_ack_o |=> $stable(wb_dat_o))
    else $error("read data moved");
  chk_unmapped_zero: assert property (
    ce && wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i
    && wb_adr_i >= 8'h28 |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_reset_idle: assert property (
    $fell(reset) |-> txdPin && rtsPin && !irq)
    else $error("pins not idle after reset");
  chk_start_width: assert property ($fell(txdPin) |=> !txdPin)
    else $error("start bit too short");
endmodule : uaff_chk
bind uaff_uart uaff_chk u_chk (.clk(clk), .reset(reset), .ce(ce),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
  .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o),
  .txdPin(txdPin), .rtsPin(rtsPin), .irq(irq));
`default_nettype wire

// >>> tb/uaff_remote.sv
// remote transceiver: echoes our line and drives clear-to-send
`timescale 1ns/1ps
`default_nettype none
module uaff_remote (
  input wire logic txdPin,
  input wire logic ready,
  output logic rxdPin,
  output logic ctsPin
);
  // remote frames are our own characters sent back
  assign rxdPin = txdPin;
  // asserted level is high with polarity set
  assign ctsPin = ready;
endmodule : uaff_remote
`default_nettype wire

// >>> tb/test_uart_fifo_flow_control.sv
// self-checking bench for the serial port
`timescale 1ns/1ps
`default_nettype none
`include "uaff_defines.svh"
module test_uart_fifo_flow_control;
  logic clk, reset, cyc, stb, we, ready, rxd, cts, txd, rts, irq, ack;
  logic [7:0] adr;
  logic [7:0] b[3];
  logic [31:0] dat, rdat, v;
  logic [31:0] expQ[$];
  int failures, checked, i;
  uaff_uart u_dut (.clk(clk), .reset(reset), .ce(1'h1), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(4'hF),
    .wb_stb_i(stb), .wb_cyc_i(cyc), .wb_ack_o(ack), .rxdPin(rxd),
    .txdPin(txd), .ctsPin(cts), .rtsPin(rts), .irq(irq));
  uaff_remote u_remote (.txdPin(txd), .ready(ready), .rxdPin(rxd),
    .ctsPin(cts));
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  // =====
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic [7:0] a, input logic [31:0] d,
    input logic w);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    adr <= a;
    dat <= d;
    we <= w;
    // hold the request until the edge that samples ack high
    do @(posedge clk); while (ack !== 1'h1);
    cyc <= 0;
    stb <= 0;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    bus(a, 0, 0);
  endtask : rd
  task automatic report_and_stop();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  // read data is judged in order against the noted expectations
  always @(posedge clk) begin
    if (ack === 1'h1 && we === 1'h0 && expQ.size() > 0)
      check(rdat, expQ.pop_front());
  end
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    report_and_stop();
  end
  // =====
  // scenarios
  initial begin
    {cyc, stb, we, ready, adr, dat} = 0;
    reset = 1;
    failures = 0;
    checked = 0;
    void'($urandom(32'hc66f_2bbe));
    repeat (16) @(posedge clk);
    reset <= 0;
    rd(`UAFF_OFS_LINE_STATUS, 32'h0000_0050);
    rd(8'h28, 32'h0000_0000);
    v = $urandom;
    bus(`UAFF_OFS_FIFO_THRESHOLD, v, 1);
    rd(`UAFF_OFS_FIFO_THRESHOLD, v & `UAFF_WM_THRESHOLD);
    bus(`UAFF_OFS_FIFO_THRESHOLD, 32'h0002_0001, 1);
    bus(`UAFF_OFS_RATE_INTEGER, 32'h0004_0001, 1);
    bus(`UAFF_OFS_IRQ_ENABLE, 32'h0000_0010, 1);
    bus(`UAFF_OFS_LINE_CONTROL, 32'h0000_1801, 1);
    // clear-to-send held off: one push past full is dropped
    for (i = 0; i < 33; i++) bus(`UAFF_OFS_DATA_PORT, $urandom, 1);
    rd(`UAFF_OFS_LINE_STATUS, 32'h0020_0090);
    check(txd, 1);
    bus(`UAFF_OFS_LINE_CONTROL, 32'h0000_1821, 1);
    rd(`UAFF_OFS_LINE_CONTROL, 32'h0000_1801);
    rd(`UAFF_OFS_LINE_STATUS, 32'h0000_0050);
    for (i = 0; i < 3; i++) begin
      b[i] = $urandom;
      bus(`UAFF_OFS_DATA_PORT, {24'h00_0000, b[i]}, 1);
    end
    ready <= 1;
    repeat (400) @(posedge clk);
    ready <= 0;
    check(rts, 0);
    check(irq, 1);
    // size field is zero: only the five low data bits travel
    rd(`UAFF_OFS_DATA_PORT, {27'h000_0000, b[0][4:0]});
    rd(`UAFF_OFS_DATA_PORT, {27'h000_0000, b[1][4:0]});
    // the pop lands at the taking edge, rts follows one edge later
    @(posedge clk);
    check(rts, 1);
    rd(`UAFF_OFS_DATA_PORT, {27'h000_0000, b[2][4:0]});
    bus(`UAFF_OFS_IRQ_FLAGS, 32'hFFFF_FFFF, 1);
    check(irq, 0);
    bus(`UAFF_OFS_DATA_PORT, $urandom, 1);
    rd(`UAFF_OFS_LINE_STATUS, 32'h0001_0010);
    bus(`UAFF_OFS_LINE_CONTROL, 32'h0000_0000, 1);
    rd(`UAFF_OFS_LINE_STATUS, 32'h0000_0050);
    repeat (4) @(posedge clk);
    report_and_stop();
  end
endmodule : test_uart_fifo_flow_control
`default_nettype wire
